// ---- shared/csbu_regs.vh ----
// constants for the compare, skip and branch unit
`ifndef CSBU_REGS_VH
`define CSBU_REGS_VH

// apb register byte offsets
`define CSBU_FLAG_REG_ADDR 8'h00
`define CSBU_PC_REG_ADDR 8'h04
`define CSBU_STAT_REG_ADDR 8'h08

// flag register bit positions
`define CSBU_F_C 3'h0
`define CSBU_F_Z 3'h1
`define CSBU_F_N 3'h2
`define CSBU_F_V 3'h3
`define CSBU_F_S 3'h4
`define CSBU_F_H 3'h5
`define CSBU_F_T 3'h6
`define CSBU_F_I 3'h7

// reset values
`define CSBU_FLAG_RST 8'h00
`define CSBU_PC_RST 16'h0000

// status register field positions
`define CSBU_ST_BUSY 0
`define CSBU_ST_SKIP 1
`define CSBU_ST_TAKEN 2
`define CSBU_ST_CYC_LO 4
`define CSBU_ST_CYC_HI 5

// operation codes on the issue port
`define CSBU_OP_COMPARE_SKIP_EQUAL 5'h00
`define CSBU_OP_COMPARE_REGS 5'h01
`define CSBU_OP_COMPARE_WITH_BORROW 5'h02
`define CSBU_OP_COMPARE_IMMEDIATE 5'h03
`define CSBU_OP_SKIP_REG_BIT_CLEAR 5'h04
`define CSBU_OP_SKIP_REG_BIT_SET 5'h05
`define CSBU_OP_SKIP_IO_BIT_CLEAR 5'h06
`define CSBU_OP_SKIP_IO_BIT_SET 5'h07
`define CSBU_OP_BRANCH_STATUS_BIT_SET 5'h08
`define CSBU_OP_BRANCH_STATUS_BIT_CLEAR 5'h09
`define CSBU_OP_BRANCH_EQUAL 5'h0a
`define CSBU_OP_BRANCH_NOT_EQUAL 5'h0b
`define CSBU_OP_BRANCH_BORROW_SET 5'h0c
`define CSBU_OP_BRANCH_BORROW_CLEAR 5'h0d
`define CSBU_OP_BRANCH_SAME_OR_HIGHER 5'h0e
`define CSBU_OP_BRANCH_LOWER 5'h0f
`define CSBU_OP_BRANCH_NEGATIVE 5'h10
`define CSBU_OP_BRANCH_POSITIVE 5'h11
`define CSBU_OP_BRANCH_SIGNED_GE 5'h12
`define CSBU_OP_BRANCH_SIGNED_LESS 5'h13
`define CSBU_OP_BRANCH_NIBBLE_CARRY_SET 5'h14
`define CSBU_OP_BRANCH_NIBBLE_CARRY_CLEAR 5'h15
`define CSBU_OP_BRANCH_USER_FLAG_SET 5'h16
`define CSBU_OP_BRANCH_USER_FLAG_CLEAR 5'h17

// execution cycle counts
`define CSBU_CYC_PLAIN 2'h1
`define CSBU_CYC_TAKEN 2'h2
`define CSBU_CYC_SKIP_ONE 2'h2
`define CSBU_CYC_SKIP_TWO 2'h3

`endif

// ---- rtl/csbu_top.v ----
// compare, skip and branch execution unit with apb access
`include "csbu_regs.vh"

// Function
// RQ1: equal registers skip next, flags untouched
// RQ2: compares subtract, discard, update five flags; the code updates six (h, s, v, n, z, c)
// RQ3: skip when register bit is clear
// RQ4: skip when register bit is set
// RQ5: skip when io bit is clear
// RQ6: skip when io bit is set
// RQ7: skip adds two or three, cycles match
// RQ8: branch on chosen flag bit, pc+k+1
// RQ9: equal branches follow zero flag
// RQ10: borrow and lower branches follow carry
// RQ11: sign branches follow negative flag
// RQ12: signed branches follow negative xor overflow
// RQ13: nibble branches follow half carry
// RQ14: user branches follow user flag
// RQ15: branch one or two cycles, signed offset
module csbu_top #(
    parameter PC_W = 16
) (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // instruction issue
    input wire ISSUE,
    input wire [4:0] OPCODE,
    input wire [7:0] RD_VAL,
    input wire [7:0] RR_VAL,
    input wire [7:0] IMM_VAL,
    input wire [7:0] IO_VAL,
    input wire [2:0] BIT_SEL,
    input wire [6:0] OFFSET,
    input wire NEXT_TWO_WORD,
    // execution results
    output reg BUSY,
    output reg DONE,
    output reg [PC_W-1:0] PC_OUT,
    output reg [7:0] FLAGS_OUT,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR
);

    // status flags from an 8-bit subtract with borrow-in
    function [5:0] sub_flags;
        input [7:0] a;
        input [7:0] b;
        input cin;
        reg [8:0] d;
        reg [4:0] lo;
        reg v;
        begin
            d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
            // order: h, s, v, n, z, c
            sub_flags = {lo[4], d[7] ^ v, v, d[7], d[7:0] == 8'h00, d[8]};
        end
    endfunction

    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_n;
    reg [1:0] rem_ff;
    reg [PC_W-1:0] pend_pc_ff;
    reg last_skip_ff;
    reg last_taken_ff;
    reg [1:0] last_cyc_ff;
    reg [7:0] nxt_flags;
    reg [PC_W-1:0] nxt_pc;
    reg [1:0] nxt_cyc;
    reg nxt_skip;
    reg nxt_taken;
    reg cond;
    reg skip_cond;
    reg is_branch;
    reg is_skip;
    reg [5:0] fl;
    reg [7:0] cmp_b;
    reg cmp_cin;
    reg is_cmp;
    wire [PC_W-1:0] offs_ext;
    wire [PC_W-1:0] pc_plain;
    wire [PC_W-1:0] pc_skip;
    wire [PC_W-1:0] pc_branch;
    wire issue_ok;
    wire apb_setup;
    wire apb_wr;
    wire idx_ok;

    // reset release through two flops, assert stays asynchronous
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // a new instruction is refused while one is still executing
    assign issue_ok = ISSUE & ~BUSY;

    // RQ15: sign-extended offset
    assign offs_ext = {{(PC_W-7){OFFSET[6]}}, OFFSET};
    // RQ8: target pc plus k plus one
    assign pc_branch = PC_OUT + offs_ext + {{(PC_W-1){1'b0}}, 1'b1};
    assign pc_plain = PC_OUT + {{(PC_W-1){1'b0}}, 1'b1};
    // RQ7: skip over one or two words
    assign pc_skip = PC_OUT + (NEXT_TWO_WORD ? {{(PC_W-2){1'b0}}, 2'h3} :
        {{(PC_W-2){1'b0}}, 2'h2});

    // compare operand selection and flag update
    always @* begin
        is_cmp = 1'b1;
        cmp_b = RR_VAL;
        cmp_cin = 1'b0;
        case (OPCODE)
            `CSBU_OP_COMPARE_REGS: begin
                cmp_b = RR_VAL;
            end
            `CSBU_OP_COMPARE_WITH_BORROW: begin
                cmp_cin = FLAGS_OUT[`CSBU_F_C];
            end
            `CSBU_OP_COMPARE_IMMEDIATE: begin
                cmp_b = IMM_VAL;
            end
            default: begin
                is_cmp = 1'b0;
            end
        endcase
        fl = sub_flags(RD_VAL, cmp_b, cmp_cin);
        nxt_flags = FLAGS_OUT;
        // RQ2: flags only, difference dropped
        if (is_cmp) begin
            nxt_flags[`CSBU_F_H] = fl[5];
            nxt_flags[`CSBU_F_S] = fl[4];
            nxt_flags[`CSBU_F_V] = fl[3];
            nxt_flags[`CSBU_F_N] = fl[2];
            // borrow form keeps zero only if it already held
            if (OPCODE == `CSBU_OP_COMPARE_WITH_BORROW) begin
                nxt_flags[`CSBU_F_Z] = fl[1] & FLAGS_OUT[`CSBU_F_Z];
            end else begin
                nxt_flags[`CSBU_F_Z] = fl[1];
            end
            nxt_flags[`CSBU_F_C] = fl[0];
        end
    end

    // skip and branch condition decode
    always @* begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        skip_cond = 1'b0;
        cond = 1'b0;
        case (OPCODE)
            // RQ1: equal registers skip
            `CSBU_OP_COMPARE_SKIP_EQUAL: skip_cond = RD_VAL == RR_VAL;
            // RQ3: register bit clear
            `CSBU_OP_SKIP_REG_BIT_CLEAR: skip_cond = ~RR_VAL[BIT_SEL];
            // RQ4: register bit set
            `CSBU_OP_SKIP_REG_BIT_SET: skip_cond = RR_VAL[BIT_SEL];
            // RQ5: io bit clear
            `CSBU_OP_SKIP_IO_BIT_CLEAR: skip_cond = ~IO_VAL[BIT_SEL];
            // RQ6: io bit set
            `CSBU_OP_SKIP_IO_BIT_SET: skip_cond = IO_VAL[BIT_SEL];
            default: is_skip = 1'b0;
        endcase
        if (!is_skip) begin
            is_branch = 1'b1;
            case (OPCODE)
                // RQ8: chosen flag set or clear
                `CSBU_OP_BRANCH_STATUS_BIT_SET: cond = FLAGS_OUT[BIT_SEL];
                `CSBU_OP_BRANCH_STATUS_BIT_CLEAR: cond = ~FLAGS_OUT[BIT_SEL];
                // RQ9: zero flag tests
                `CSBU_OP_BRANCH_EQUAL: cond = FLAGS_OUT[`CSBU_F_Z];
                `CSBU_OP_BRANCH_NOT_EQUAL: cond = ~FLAGS_OUT[`CSBU_F_Z];
                // RQ10: carry flag tests
                `CSBU_OP_BRANCH_BORROW_SET: cond = FLAGS_OUT[`CSBU_F_C];
                `CSBU_OP_BRANCH_LOWER: cond = FLAGS_OUT[`CSBU_F_C];
                `CSBU_OP_BRANCH_BORROW_CLEAR: cond = ~FLAGS_OUT[`CSBU_F_C];
                `CSBU_OP_BRANCH_SAME_OR_HIGHER: cond = ~FLAGS_OUT[`CSBU_F_C];
                // RQ11: negative flag tests
                `CSBU_OP_BRANCH_NEGATIVE: cond = FLAGS_OUT[`CSBU_F_N];
                `CSBU_OP_BRANCH_POSITIVE: cond = ~FLAGS_OUT[`CSBU_F_N];
                // RQ12: negative xor overflow
                `CSBU_OP_BRANCH_SIGNED_GE:
                    cond = ~(FLAGS_OUT[`CSBU_F_N] ^ FLAGS_OUT[`CSBU_F_V]);
                `CSBU_OP_BRANCH_SIGNED_LESS:
                    cond = FLAGS_OUT[`CSBU_F_N] ^ FLAGS_OUT[`CSBU_F_V];
                // RQ13: half carry tests
                `CSBU_OP_BRANCH_NIBBLE_CARRY_SET: cond = FLAGS_OUT[`CSBU_F_H];
                `CSBU_OP_BRANCH_NIBBLE_CARRY_CLEAR:
                    cond = ~FLAGS_OUT[`CSBU_F_H];
                // RQ14: user flag tests
                `CSBU_OP_BRANCH_USER_FLAG_SET: cond = FLAGS_OUT[`CSBU_F_T];
                `CSBU_OP_BRANCH_USER_FLAG_CLEAR: cond = ~FLAGS_OUT[`CSBU_F_T];
                default: is_branch = 1'b0;
            endcase
        end
    end

    // next pc and cycle count of the issued instruction
    always @* begin
        nxt_pc = pc_plain;
        nxt_cyc = `CSBU_CYC_PLAIN;
        nxt_skip = 1'b0;
        nxt_taken = 1'b0;
        // RQ7: skip length sets cycles
        if (is_skip && skip_cond) begin
            nxt_pc = pc_skip;
            nxt_skip = 1'b1;
            nxt_cyc = NEXT_TWO_WORD ? `CSBU_CYC_SKIP_TWO :
                `CSBU_CYC_SKIP_ONE;
        end
        // RQ15: taken branch two cycles
        if (is_branch && cond) begin
            nxt_pc = pc_branch;
            nxt_taken = 1'b1;
            nxt_cyc = `CSBU_CYC_TAKEN;
        end
    end

    // apb decode; zero wait, answer in the first access cycle
    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr = PSEL & PENABLE & PWRITE & PREADY;
    assign idx_ok = (PADDR == `CSBU_FLAG_REG_ADDR) |
        (PADDR == `CSBU_PC_REG_ADDR) | (PADDR == `CSBU_STAT_REG_ADDR);

    // execution sequencer; pc moves at the last cycle only
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            rem_ff <= 2'h0;
            PC_OUT <= `CSBU_PC_RST;
            pend_pc_ff <= `CSBU_PC_RST;
            FLAGS_OUT <= `CSBU_FLAG_RST;
            last_skip_ff <= 1'b0;
            last_taken_ff <= 1'b0;
            last_cyc_ff <= 2'h0;
        end else begin
            DONE <= 1'b0;
            if (issue_ok) begin
                // flags settle at issue; skips and branches leave them
                FLAGS_OUT <= nxt_flags;
                pend_pc_ff <= nxt_pc;
                rem_ff <= nxt_cyc;
                BUSY <= 1'b1;
                last_skip_ff <= nxt_skip;
                last_taken_ff <= nxt_taken;
                last_cyc_ff <= nxt_cyc;
            end else if (BUSY) begin
                rem_ff <= rem_ff - 2'h1;
                if (rem_ff == 2'h1) begin
                    BUSY <= 1'b0;
                    DONE <= 1'b1;
                    PC_OUT <= pend_pc_ff;
                end
            end else if (apb_wr && PADDR == `CSBU_FLAG_REG_ADDR) begin
                // software writes only land between instructions
                FLAGS_OUT <= PWDATA[7:0];
            end else if (apb_wr && PADDR == `CSBU_PC_REG_ADDR) begin
                PC_OUT <= PWDATA[PC_W-1:0];
            end
        end
    end

    // apb answer registered in the setup cycle
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup & ~idx_ok;
            PRDATA <= 32'h00000000;
            if (apb_setup && !PWRITE) begin
                case (PADDR)
                    `CSBU_FLAG_REG_ADDR: PRDATA[7:0] <= FLAGS_OUT;
                    `CSBU_PC_REG_ADDR: PRDATA[PC_W-1:0] <= PC_OUT;
                    `CSBU_STAT_REG_ADDR: begin
                        PRDATA[`CSBU_ST_BUSY] <= BUSY;
                        PRDATA[`CSBU_ST_SKIP] <= last_skip_ff;
                        PRDATA[`CSBU_ST_TAKEN] <= last_taken_ff;
                        PRDATA[`CSBU_ST_CYC_HI:`CSBU_ST_CYC_LO] <=
                            last_cyc_ff;
                    end
                    default: PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // csbu_top

// ---- dv/csbu_props.sv ----
// assertion checker for the compare, skip and branch unit
module csbu_props #(
    parameter PC_W = 16
) (
    // clock and reset
    input wire CLK,
    input wire RST_B,
    // issue side
    input wire ISSUE,
    input wire [4:0] OPCODE,
    input wire [7:0] RD_VAL,
    input wire [7:0] RR_VAL,
    input wire [7:0] IO_VAL,
    input wire [2:0] BIT_SEL,
    input wire [6:0] OFFSET,
    input wire NEXT_TWO_WORD,
    // results
    input wire BUSY,
    input wire DONE,
    input wire [PC_W-1:0] PC_OUT,
    input wire [7:0] FLAGS_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // an issue counts only while idle
    wire take = ISSUE && !BUSY && !DONE;
    wire eq = RD_VAL == RR_VAL;
    wire [PC_W-1:0] tgt = PC_OUT + {{(PC_W-7){OFFSET[6]}}, OFFSET} + 1'b1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_cmp_one_cycle: assert property (
        take && OPCODE inside {5'h01, 5'h02, 5'h03} |=> !DONE ##1 DONE)
        else $error("compare not one cycle");
    a_cmp_zero_flag: assert property (
        take && OPCODE == 5'h01 |=> FLAGS_OUT[1] == $past(eq))
        else $error("compare zero flag wrong");
    a_equal_skip_far: assert property (
        take && OPCODE == 5'h00 && eq && NEXT_TWO_WORD |=>
        !DONE [*3] ##1 DONE && PC_OUT == $past(PC_OUT, 4) + 2'h3)
        else $error("long equal skip wrong");
    a_skip_flags_kept: assert property (
        take && OPCODE inside {5'h00, [5'h04:5'h07]} |=>
        $stable(FLAGS_OUT) [*2])
        else $error("skip changed flags");
    a_set_bit_noskip: assert property (
        take && OPCODE == 5'h05 && !RR_VAL[BIT_SEL] |=>
        !DONE ##1 DONE && PC_OUT == $past(PC_OUT, 2) + 1'b1)
        else $error("set bit skip wrong");
    a_io_clear_skip: assert property (
        take && OPCODE == 5'h06 && !IO_VAL[BIT_SEL] && !NEXT_TWO_WORD |=>
        !DONE [*2] ##1 DONE && PC_OUT == $past(PC_OUT, 3) + 2'h2)
        else $error("io clear skip wrong");
    a_equal_branch: assert property (
        take && OPCODE == 5'h0a && FLAGS_OUT[1] |=>
        !DONE [*2] ##1 DONE && PC_OUT == $past(tgt, 3))
        else $error("equal branch wrong");
    a_signed_less: assert property (
        take && OPCODE == 5'h13 && FLAGS_OUT[2] == FLAGS_OUT[3] |=>
        !DONE ##1 DONE && PC_OUT == $past(PC_OUT, 2) + 1'b1)
        else $error("signed less branch wrong");
endmodule // csbu_props

bind csbu_top csbu_props #(.PC_W(PC_W)) props_u (.*);

// ---- dv/csbu_space.sv ----
// behavioural register file and io space feeding the operand ports
module csbu_space (
    // clock and write side
    input wire clk,
    input wire we,
    input wire [7:0] wdata,
    // read side
    input wire [2:0] a_idx,
    input wire [2:0] b_idx,
    input wire [2:0] p_idx,
    output wire [7:0] a_val,
    output wire [7:0] b_val,
    output wire [7:0] p_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [8] = '{8'h00, 8'h5a, 8'hff, 8'h80,
        8'h01, 8'h7f, 8'h3c, 8'hc3};
    // io space is the inverted file, so its bits differ from the registers
    assign a_val = regs[a_idx];
    assign b_val = regs[b_idx];
    assign p_val = ~regs[p_idx];
    // writes land at the edge like a real register file
    always @(posedge clk)
        if (we)
            regs[a_idx] <= wdata;
endmodule // csbu_space

// ---- dv/csbu_top_bench.sv ----
// self-checking bench for the compare, skip and branch unit
`include "csbu_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
$display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module csbu_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_B = 1'b0, ISSUE = 1'b0, NEXT_TWO_WORD = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, we = 1'b0, err;
    logic [4:0] OPCODE = 5'h00;
    logic [7:0] IMM_VAL = 8'h00, PADDR = 8'h00, wd = 8'h00, m_fl;
    logic [2:0] BIT_SEL = 3'h0, ai = 3'h0, bi = 3'h0, pi = 3'h0;
    logic [6:0] OFFSET = 7'h00;
    logic [31:0] PWDATA = 32'h0, q;
    logic [15:0] m_pc;
    wire [7:0] RD_VAL, RR_VAL, IO_VAL, FLAGS_OUT;
    wire [15:0] PC_OUT;
    wire [31:0] PRDATA;
    wire BUSY, DONE, PREADY, PSLVERR;
    integer seed = 32'ha356, n_errors = 0, total_checks = 0, cycles = 0;

    // operand source and the unit
    csbu_space space_u (.clk(CLK), .we(we), .wdata(wd), .a_idx(ai),
        .b_idx(bi), .p_idx(pi), .a_val(RD_VAL), .b_val(RR_VAL),
        .p_val(IO_VAL));
    csbu_top dut_u (.*);

    always #5 CLK = ~CLK;

    // watchdog so a hung handshake still ends the run
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // no wait limit here: only the watchdog ends a hung transfer
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    // one instruction; issue held two cycles so the second is refused
    task exec(input logic [4:0] op);
        logic [7:0] r, d, f;
        logic v, sk, tk, c;
        int n, cy;
        f = 8'($random(seed));
        m_pc = 16'($random(seed));
        apb(1'b1, `CSBU_FLAG_REG_ADDR, {24'h0, f});
        apb(1'b1, `CSBU_PC_REG_ADDR, {16'h0, m_pc});
        r = 8'($random(seed));
        ai <= r[2:0];
        bi <= r[3] ? r[2:0] : r[6:4];
        pi <= r[6:4];
        {wd, IMM_VAL, OFFSET, BIT_SEL, NEXT_TWO_WORD} <= 27'($random(seed));
        we <= 1'b1;
        @(posedge CLK);
        we <= 1'b0;
        ISSUE <= 1'b1;
        OPCODE <= op;
        @(posedge CLK);
        m_fl = f;
        d = op == 5'h03 ? IMM_VAL : RR_VAL;
        c = op == 5'h02 && f[0];
        r = RD_VAL - d - c;
        if (op inside {5'h01, 5'h02, 5'h03}) begin
            m_fl[0] = {1'b0, RD_VAL} < {1'b0, d} + c;
            m_fl[1] = r == 8'h00 && (op != 5'h02 || f[1]);
            m_fl[2] = r[7];
            m_fl[3] = RD_VAL[7] & !d[7] & !r[7] | !RD_VAL[7] & d[7] & r[7];
            m_fl[5] = !RD_VAL[3] & d[3] | d[3] & r[3] | r[3] & !RD_VAL[3];
        end
        case (op)
            5'h00: v = RD_VAL == RR_VAL;
            5'h04, 5'h05: v = RR_VAL[BIT_SEL];
            5'h06, 5'h07: v = IO_VAL[BIT_SEL];
            5'h08, 5'h09: v = f[BIT_SEL];
            5'h0a, 5'h0b: v = f[1];
            5'h10, 5'h11: v = f[2];
            5'h12, 5'h13: v = f[2] ^ f[3];
            5'h14, 5'h15: v = f[5];
            5'h16, 5'h17: v = f[6];
            default: v = f[0];
        endcase
        v = v == (op inside {5'h00, 5'h05, 5'h07, 5'h08, 5'h0a, 5'h0c,
            5'h0f, 5'h10, 5'h13, 5'h14, 5'h16});
        sk = v && op inside {5'h00, [5'h04:5'h07]};
        tk = v && op > 5'h07;
        cy = tk ? 2 : sk ? 2 + NEXT_TWO_WORD : 1;
        m_pc = m_pc + (tk ? {{9{OFFSET[6]}}, OFFSET} + 16'h1 : 16'(cy));
        n = 0;
        do begin
            @(posedge CLK);
            ISSUE <= 1'b0;
            n++;
            if (DONE !== 1'b1) `CHK(BUSY, 1'b1)
        end while (DONE !== 1'b1 && n < 9);
        `CHK(n, cy + 1)
        `CHK(PC_OUT, m_pc)
        `CHK(FLAGS_OUT & 8'hef, m_fl & 8'hef)
        apb(1'b0, `CSBU_STAT_REG_ADDR, 32'h0);
        `CHK({err, q[5:4], q[2:0]}, {1'b0, 2'(cy), tk, sk, 1'b0})
    endtask

    // reset, an unmapped slot, then every code many times
    initial begin
        repeat (6) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLK);
        apb(1'b0, `CSBU_PC_REG_ADDR, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        `CHK({err, q}, {1'b1, 32'h0})
        for (int i = 0; i < 288; i++)
            exec(5'(i % 24));
        tally_and_finish;
    end
endmodule // csbu_top_bench
